// >>> siow_chk.sv
// checker for the watchdog: concurrent assertions on the top-level ports
// assumes it is bound to siow_watchdog and sees only its ports
`timescale 1ns/10ps
module siow_chk (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       clk_en_i,
   // host i/o port
   input  wire logic [7:0] io_addr_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic [7:0] io_rdata_o,
   input  wire logic       io_rvalid_o,
   // timeout signal
   input  wire logic       wdt_timeout_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic       open_q, key_q, sel_q, st_q;
   logic [7:0] idx_q;
   logic [1:0] en_q;
   // decoded accesses and shadow status
   wire aw   = clk_en_i && io_wr_i && io_addr_i == siow_pkg::ADDR_PORT;
   wire dw   = clk_en_i && io_wr_i && open_q && io_addr_i == siow_pkg::DATA_PORT;
   wire cw   = dw && sel_q && idx_q == siow_pkg::IDX_CTRL;
   wire rdp  = clk_en_i && io_rd_i && io_addr_i[7:1] == 7'h17;
   wire dr   = rdp && io_addr_i == siow_pkg::DATA_PORT;
   wire stat = st_q || wdt_timeout_o;
   // shadow of key sequence, lock state and index
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         open_q <= 1'b0;
         key_q  <= 1'b0;
         idx_q  <= 8'h00;
      end else if (aw && open_q) begin
         open_q <= io_wdata_i != siow_pkg::KEY_LOCK;
         // the relock key never becomes the index
         if (io_wdata_i != siow_pkg::KEY_LOCK) begin
            idx_q <= io_wdata_i;
         end
      end else if (aw) begin
         open_q <= key_q && io_wdata_i == siow_pkg::KEY_UNLOCK;
         key_q  <= !key_q && io_wdata_i == siow_pkg::KEY_UNLOCK;
      end
   end
   // shadow of selector, refresh enables and sticky status
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q <= 1'b0;
         en_q  <= 2'b00;
         st_q  <= 1'b0;
      end else begin
         if (dw && idx_q == siow_pkg::IDX_UNIT_SEL) sel_q <= io_wdata_i == siow_pkg::SEL_WATCHDOG;
         if (cw) en_q <= io_wdata_i[7:6];
         st_q <= wdt_timeout_o || (st_q && !(cw && !io_wdata_i[4]));
      end
   end
   sequence s_ctrl_rd;
      dr && open_q && sel_q && idx_q == siow_pkg::IDX_CTRL;
   endsequence
   sequence s_relock;
      aw && open_q && io_wdata_i == siow_pkg::KEY_LOCK;
   endsequence
   sequence s_force;
      cw && io_wdata_i[5];
   endsequence
   property p_rv_cause;  io_rvalid_o |-> $past(rdp); endproperty
   property p_locked;    !open_q && rdp |=> !io_rvalid_o; endproperty
   property p_relock;    s_relock ##[1:2] rdp |=> !io_rvalid_o; endproperty
   property p_unsel;
      io_rvalid_o && $past(dr) && !$past(sel_q) && $past(idx_q) != siow_pkg::IDX_UNIT_SEL
         |-> io_rdata_o == 8'hff;
   endproperty
   property p_rst_quiet; !$past(rst_n_i) |-> !wdt_timeout_o && !io_rvalid_o; endproperty
   property p_force;     s_force |=> wdt_timeout_o; endproperty
   property p_force_rd;  s_ctrl_rd |=> !io_rdata_o[5]; endproperty
   property p_status;    s_ctrl_rd |=> io_rdata_o[4] == $past(stat); endproperty
   property p_enables;   s_ctrl_rd |=> io_rdata_o[7:6] == $past(en_q); endproperty
   a_rv_cause:  assert property (p_rv_cause) else $error("read data valid without a read");
   a_locked:    assert property (p_locked) else $error("read answered while locked");
   a_relock:    assert property (p_relock) else $error("read answered after relock");
   a_unsel:     assert property (p_unsel) else $error("unselected read not ff");
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   a_force:     assert property (p_force) else $error("forced timeout missing");
   a_force_rd:  assert property (p_force_rd) else $error("force bit reads one");
   a_status:    assert property (p_status) else $error("status bit wrong");
   a_enables:   assert property (p_enables) else $error("refresh enables wrong");
endmodule : siow_chk

bind siow_watchdog siow_chk siow_chk_i (.core_clk_i, .rst_n_i, .clk_en_i, .io_addr_i,
   .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .wdt_timeout_o);

// >>> siow_pkg.sv
// package for the super i/o watchdog: port addresses, register indices,
// field positions, reset values and timing counts.
// assumes a 25 MHz core clock.
package siow_pkg;
   // i/o port decode
   localparam logic [7:0] ADDR_PORT      = 8'h2e;
   localparam logic [7:0] DATA_PORT      = 8'h2f;
   // address-port key values
   localparam logic [7:0] KEY_UNLOCK     = 8'h87;
   localparam logic [7:0] KEY_LOCK       = 8'haa;
   // register indices
   localparam logic [7:0] IDX_UNIT_SEL   = 8'h07;
   localparam logic [7:0] IDX_FUNC_EN    = 8'h30;
   localparam logic [7:0] IDX_UNIT_CFG   = 8'hf5;
   localparam logic [7:0] IDX_COUNT      = 8'hf6;
   localparam logic [7:0] IDX_CTRL       = 8'hf7;
   // selector value for the watchdog register set
   localparam logic [7:0] SEL_WATCHDOG   = 8'h08;
   // field positions
   localparam int         FEN_BIT        = 0;
   localparam int         CFG_MINUTES    = 3;
   localparam int         CFG_FAST       = 4;
   localparam int         CTRL_STATUS    = 4;
   localparam int         CTRL_FORCE     = 5;
   localparam int         CTRL_KBD_EN    = 6;
   localparam int         CTRL_MS_EN     = 7;
   // reset values
   localparam logic [7:0] RST_UNIT_SEL   = 8'h00;
   localparam logic [7:0] RST_FUNC_EN    = 8'h00;
   localparam logic [7:0] RST_UNIT_CFG   = 8'h00;
   localparam logic [7:0] RST_COUNT      = 8'h00;
   localparam logic [7:0] RST_CTRL       = 8'h00;
   // timing: clock rate and tick lengths
   localparam longint     CLK_HZ         = 25_000_000;
   localparam longint     MS_PER_S       = 1000;
   localparam longint     S_PER_MIN      = 60;
   localparam longint     CYC_PER_MS     = CLK_HZ / MS_PER_S;
   localparam longint     CYC_PER_S      = CLK_HZ;
   localparam longint     FAST_PER_MIN   = 1000;
   localparam longint     CYC_PER_FMIN   = CLK_HZ * S_PER_MIN / FAST_PER_MIN;
   localparam longint     CYC_PER_MIN    = CLK_HZ * S_PER_MIN;
   // unit select encoding {fast, minutes}
   typedef enum logic [1:0] {
      SIOW_U_SEC  = 2'b00,
      SIOW_U_MIN  = 2'b01,
      SIOW_U_FSEC = 2'b10,
      SIOW_U_FMIN = 2'b11
   } siow_unit_t;
endpackage : siow_pkg

// >>> siow_prescaler.sv
// tick prescaler: one pulse per selected counting unit.
// assumes a synchronous clock enable and a core-side restart pulse.
`timescale 1ns/10ps
module siow_prescaler #(
   parameter longint CYC_MS   = siow_pkg::CYC_PER_MS,
   parameter longint CYC_S    = siow_pkg::CYC_PER_S,
   parameter longint CYC_FMIN = siow_pkg::CYC_PER_FMIN,
   parameter longint CYC_MIN  = siow_pkg::CYC_PER_MIN
) (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic clk_en_i,
   // core link
   siow_tick_if.presc tk
);
   initial begin
      if (CYC_MS < 1 || CYC_S < 1 || CYC_FMIN < 1 || CYC_MIN < 1 ||
          CYC_MIN > 64'h0000_0000_ffff_ffff)
         $error("siow_prescaler: tick lengths out of range");
   end

   logic [31:0] cnt_q;
   logic [31:0] limit;

   // end count of the selected unit
   always_comb begin
      unique case (tk.unit)
         siow_pkg::SIOW_U_SEC:  limit = 32'(CYC_S - 1);
         siow_pkg::SIOW_U_MIN:  limit = 32'(CYC_MIN - 1);
         siow_pkg::SIOW_U_FSEC: limit = 32'(CYC_MS - 1);
         siow_pkg::SIOW_U_FMIN: limit = 32'(CYC_FMIN - 1);
      endcase
   end

   // cycle counter, restarted by a reload so a full unit follows it
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 32'h0000_0000;
      end else if (clk_en_i) begin
         if (tk.restart || !tk.run || cnt_q >= limit) begin
            cnt_q <= 32'h0000_0000;
         end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
   end

   assign tk.tick = clk_en_i && tk.run && !tk.restart && (cnt_q >= limit);
endmodule : siow_prescaler

// >>> siow_tick_if.sv
// interface between the watchdog core and its tick prescaler.
// assumes both ends share one clock.
`timescale 1ns/10ps
interface siow_tick_if;
   logic                      restart;
   logic                      run;
   siow_pkg::siow_unit_t      unit;
   logic                      tick;
   modport core (output restart, output run, output unit, input tick);
   modport presc (input restart, input run, input unit, output tick);
endinterface : siow_tick_if

// >>> siow_watchdog.sv
// super i/o watchdog timer behind an index/data i/o port pair.
// assumes synchronous host i/o strobes, one per access, and synchronous
// keyboard/mouse activity pulses.
`timescale 1ns/10ps
module siow_watchdog #(
   parameter longint CYC_MS   = siow_pkg::CYC_PER_MS,
   parameter longint CYC_S    = siow_pkg::CYC_PER_S,
   parameter longint CYC_FMIN = siow_pkg::CYC_PER_FMIN,
   parameter longint CYC_MIN  = siow_pkg::CYC_PER_MIN
) (
   // clock, reset, enable
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       clk_en_i,
   // host i/o port
   input  wire logic [7:0] io_addr_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_wdata_i,
   output      logic [7:0] io_rdata_o,
   output      logic       io_rvalid_o,
   // activity sources
   input  wire logic       kbd_activity_i,
   input  wire logic       mouse_activity_i,
   // timeout signal
   output      logic       wdt_timeout_o
);
   typedef enum logic [1:0] {
      SIOW_LOCKED = 2'b00,
      SIOW_KEY1   = 2'b01,
      SIOW_OPEN   = 2'b11
   } siow_lock_t;

   siow_lock_t  lock_q;
   logic [7:0]  index_q;
   logic [7:0]  unit_sel_q;
   logic [7:0]  func_en_q;
   logic [7:0]  unit_cfg_q;
   logic [7:0]  count_q;
   logic [7:0]  remain_q;
   logic        kbd_en_q;
   logic        ms_en_q;
   logic        status_q;
   logic        timeout_q;
   logic [7:0]  rdata_q;
   logic        rvalid_q;

   logic        open;
   logic        addr_wr;
   logic        data_wr;
   logic        data_rd;
   logic        wd_sel;
   logic        running;
   logic        refresh;
   logic        load;
   logic        expire;
   logic        force_to;
   logic        status_clr;
   logic [7:0]  ctrl_rd;

   siow_tick_if tk ();

   // decode of the two ports
   assign open    = (lock_q == SIOW_OPEN);
   assign addr_wr = io_wr_i && (io_addr_i == siow_pkg::ADDR_PORT);
   assign data_wr = io_wr_i && (io_addr_i == siow_pkg::DATA_PORT) && open;
   assign data_rd = io_rd_i && (io_addr_i == siow_pkg::DATA_PORT) && open;
   assign wd_sel  = (unit_sel_q == siow_pkg::SEL_WATCHDOG);

   function automatic logic wd_hit(input logic [7:0] idx, input logic [7:0] want,
                                   input logic sel);
      wd_hit = sel && (idx == want);
   endfunction : wd_hit

   // key sequence: two 87s back to back open, aa closes
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_q <= SIOW_LOCKED;
      end else if (clk_en_i && addr_wr) begin
         unique case (lock_q)
            SIOW_LOCKED: begin
               lock_q <= (io_wdata_i == siow_pkg::KEY_UNLOCK) ? SIOW_KEY1 : SIOW_LOCKED;
            end
            SIOW_KEY1: begin
               lock_q <= (io_wdata_i == siow_pkg::KEY_UNLOCK) ? SIOW_OPEN : SIOW_LOCKED;
            end
            SIOW_OPEN: begin
               if (io_wdata_i == siow_pkg::KEY_LOCK) begin
                  lock_q <= SIOW_LOCKED;
               end
            end
            default: lock_q <= SIOW_LOCKED;
         endcase
      end
   end

   // index latch, only while open
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         index_q <= 8'h00;
      end else if (clk_en_i && addr_wr && open && io_wdata_i != siow_pkg::KEY_LOCK) begin
         index_q <= io_wdata_i;
      end
   end

   // unit select is global; others only when the watchdog set is chosen
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unit_sel_q <= siow_pkg::RST_UNIT_SEL;
         func_en_q  <= siow_pkg::RST_FUNC_EN;
         unit_cfg_q <= siow_pkg::RST_UNIT_CFG;
         kbd_en_q   <= siow_pkg::RST_CTRL[siow_pkg::CTRL_KBD_EN];
         ms_en_q    <= siow_pkg::RST_CTRL[siow_pkg::CTRL_MS_EN];
      end else if (clk_en_i && data_wr) begin
         if (index_q == siow_pkg::IDX_UNIT_SEL) begin
            unit_sel_q <= io_wdata_i;
         end
         if (wd_hit(index_q, siow_pkg::IDX_FUNC_EN, wd_sel)) begin
            func_en_q <= io_wdata_i;
         end
         if (wd_hit(index_q, siow_pkg::IDX_UNIT_CFG, wd_sel)) begin
            unit_cfg_q <= io_wdata_i;
         end
         if (wd_hit(index_q, siow_pkg::IDX_CTRL, wd_sel)) begin
            kbd_en_q <= io_wdata_i[siow_pkg::CTRL_KBD_EN];
            ms_en_q  <= io_wdata_i[siow_pkg::CTRL_MS_EN];
         end
      end
   end

   // count register write and derived strobes
   assign load       = clk_en_i && data_wr && wd_hit(index_q, siow_pkg::IDX_COUNT, wd_sel);
   assign force_to   = clk_en_i && data_wr && wd_hit(index_q, siow_pkg::IDX_CTRL, wd_sel) &&
                       io_wdata_i[siow_pkg::CTRL_FORCE];
   assign status_clr = clk_en_i && data_wr && wd_hit(index_q, siow_pkg::IDX_CTRL, wd_sel) &&
                       !io_wdata_i[siow_pkg::CTRL_STATUS];

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q <= siow_pkg::RST_COUNT;
      end else if (load) begin
         count_q <= io_wdata_i;
      end
   end

   // activity refresh, gated by the enable bits
   assign refresh = (kbd_en_q && kbd_activity_i) ||
                    (ms_en_q && mouse_activity_i);
   assign running = func_en_q[siow_pkg::FEN_BIT] && (remain_q != 8'h00);
   assign expire  = running && tk.tick && (remain_q == 8'h01) && !refresh && !load;

   // prescaler control
   assign tk.run     = running;
   assign tk.restart = load || (running && refresh);
   assign tk.unit    = siow_pkg::siow_unit_t'({unit_cfg_q[siow_pkg::CFG_FAST],
                                               unit_cfg_q[siow_pkg::CFG_MINUTES]});

   siow_prescaler #(
      .CYC_MS   (CYC_MS),
      .CYC_S    (CYC_S),
      .CYC_FMIN (CYC_FMIN),
      .CYC_MIN  (CYC_MIN)
   ) u_presc (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .clk_en_i   (clk_en_i),
      .tk         (tk)
   );

   // remaining units: reload on write or activity, step down per tick
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         remain_q <= 8'h00;
      end else if (clk_en_i) begin
         if (load) begin
            remain_q <= io_wdata_i;
         end else if (running && refresh) begin
            remain_q <= count_q;
         end else if (running && tk.tick) begin
            remain_q <= remain_q - 8'h01;
         end
      end
   end

   // sticky status: set wins over a software clear
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= siow_pkg::RST_CTRL[siow_pkg::CTRL_STATUS];
      end else if (clk_en_i) begin
         if (expire || force_to) begin
            status_q <= 1'b1;
         end else if (status_clr) begin
            status_q <= 1'b0;
         end
      end
   end

   // timeout output: one-cycle pulse per expiry or forced timeout
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timeout_q <= 1'b0;
      end else if (clk_en_i) begin
         timeout_q <= expire || force_to;
      end
   end
   assign wdt_timeout_o = timeout_q;

   // control readback: force bit is never stored, so reads as zero
   assign ctrl_rd = {ms_en_q, kbd_en_q, 1'b0, status_q, 4'h0};

   // read data: index port or selected register, unmapped reads ff
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else if (clk_en_i) begin
         rvalid_q <= data_rd || (io_rd_i && io_addr_i == siow_pkg::ADDR_PORT && open);
         if (io_rd_i && io_addr_i == siow_pkg::ADDR_PORT && open) begin
            rdata_q <= index_q;
         end else if (data_rd) begin
            if (index_q == siow_pkg::IDX_UNIT_SEL) begin
               rdata_q <= unit_sel_q;
            end else if (wd_hit(index_q, siow_pkg::IDX_FUNC_EN, wd_sel)) begin
               rdata_q <= func_en_q;
            end else if (wd_hit(index_q, siow_pkg::IDX_UNIT_CFG, wd_sel)) begin
               rdata_q <= unit_cfg_q;
            end else if (wd_hit(index_q, siow_pkg::IDX_COUNT, wd_sel)) begin
               rdata_q <= remain_q;
            end else if (wd_hit(index_q, siow_pkg::IDX_CTRL, wd_sel)) begin
               rdata_q <= ctrl_rd;
            end else begin
               rdata_q <= 8'hff;
            end
         end
      end
   end
   assign io_rdata_o  = rdata_q;
   assign io_rvalid_o = rvalid_q;
endmodule : siow_watchdog

// >>> siow_watchdog_tb.sv
// testbench for the watchdog: lock, registers, countdown, refresh, force
// assumes short unit counts set below and a 25 MHz clock
`timescale 1ns/10ps
module siow_watchdog_tb;
   localparam int         UMS = 4, US = 8, UFM = 12, UMN = 16;
   localparam logic [7:0] AP  = siow_pkg::ADDR_PORT;
   localparam logic [7:0] DP  = siow_pkg::DATA_PORT;
   logic       core_clk_i = 1'b0;
   logic       rst_n_i    = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic       wr = 1'b0, rd = 1'b0, kbd = 1'b0, mouse = 1'b0, rvalid, tmo;
   logic       clk_en = 1'b1;
   int         mismatches = 0, compares = 0;
   siow_watchdog #(.CYC_MS(UMS), .CYC_S(US), .CYC_FMIN(UFM), .CYC_MIN(UMN)) siow_watchdog_i (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .io_addr_i(addr),
      .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata),
      .io_rvalid_o(rvalid), .kbd_activity_i(kbd), .mouse_activity_i(mouse),
      .wdt_timeout_o(tmo));
   // clock
   always #20 core_clk_i = ~core_clk_i;
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr_io(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i) #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge core_clk_i) #1;
      wr = 1'b0;
   endtask : wr_io
   task automatic rd_io(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk_i) #1;
      addr = a;
      rd = 1'b1;
      @(posedge core_clk_i) #1;
      rd = 1'b0;
      v = rvalid;
      d = rdata;
   endtask : rd_io
   task automatic set_reg(input logic [7:0] i, input logic [7:0] d);
      wr_io(AP, i);
      wr_io(DP, d);
   endtask : set_reg
   task automatic get_reg(input logic [7:0] i, output logic [7:0] d);
      logic v;
      wr_io(AP, i);
      rd_io(DP, d, v);
      chk("read valid", 8'(v), 8'h01);
   endtask : get_reg
   // counts edges until the timeout pulse, giving up after lim
   task automatic wait_tmo(input int lim, output int n);
      n = 0;
      do begin
         @(posedge core_clk_i) #1;
         n++;
      end while (tmo !== 1'b1 && n < lim);
   endtask : wait_tmo
   task automatic t_reset();
      logic [7:0] d;
      logic [7:0] idx [4] = '{8'h30, 8'hf5, 8'hf6, 8'hf7};
      logic       v;
      rd_io(DP, d, v);
      chk("locked read", 8'(v), 8'h00);
      wr_io(AP, siow_pkg::KEY_UNLOCK);
      wr_io(AP, siow_pkg::KEY_UNLOCK);
      get_reg(siow_pkg::IDX_COUNT, d);
      chk("unselected", d, 8'hff);
      set_reg(siow_pkg::IDX_UNIT_SEL, siow_pkg::SEL_WATCHDOG);
      foreach (idx[k]) begin
         get_reg(idx[k], d);
         chk("reset value", d, 8'h00);
      end
      $display("t_reset done");
   endtask : t_reset
   task automatic t_lock();
      logic [7:0] d;
      logic       v;
      wr_io(AP, siow_pkg::KEY_LOCK);
      rd_io(DP, d, v);
      chk("relocked read", 8'(v), 8'h00);
      wr_io(AP, siow_pkg::KEY_UNLOCK);
      wr_io(AP, 8'h07);
      wr_io(AP, siow_pkg::KEY_UNLOCK);
      rd_io(DP, d, v);
      chk("broken key", 8'(v), 8'h00);
      wr_io(AP, siow_pkg::KEY_UNLOCK);
      rd_io(AP, d, v);
      chk("unlocked read", 8'(v), 8'h01);
      chk("index read", d, siow_pkg::IDX_CTRL);
      $display("t_lock done");
   endtask : t_lock
   task automatic t_expire();
      logic [7:0] d;
      logic [7:0] cfg [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
      int         unit [4] = '{US, UMN, UMS, UFM};
      int         n;
      set_reg(siow_pkg::IDX_FUNC_EN, 8'h01);
      foreach (cfg[k]) begin
         set_reg(siow_pkg::IDX_UNIT_CFG, cfg[k]);
         set_reg(siow_pkg::IDX_COUNT, 8'h03);
         wait_tmo(3 * unit[k] + 10, n);
         chk("expiry", 8'(n >= 3 * unit[k] && n <= 3 * unit[k] + 3), 8'h01);
         get_reg(siow_pkg::IDX_CTRL, d);
         chk("status set", 8'(d[4]), 8'h01);
         get_reg(siow_pkg::IDX_COUNT, d);
         chk("count spent", d, 8'h00);
         set_reg(siow_pkg::IDX_CTRL, 8'h00);
         get_reg(siow_pkg::IDX_CTRL, d);
         chk("status clear", 8'(d[4]), 8'h00);
      end
      $display("t_expire done");
   endtask : t_expire
   task automatic t_refresh();
      int n;
      set_reg(siow_pkg::IDX_UNIT_CFG, 8'h10);
      set_reg(siow_pkg::IDX_COUNT, 8'h05);
      wait_tmo(2 * UMS, n);
      chk("early timeout", 8'(tmo), 8'h00);
      set_reg(siow_pkg::IDX_COUNT, 8'h04);
      wait_tmo(40, n);
      chk("rewrite", 8'(n >= 4 * UMS && n <= 4 * UMS + 3), 8'h01);
      set_reg(siow_pkg::IDX_COUNT, 8'h05);
      set_reg(siow_pkg::IDX_COUNT, 8'h00);
      wait_tmo(40, n);
      chk("zero stops", 8'(tmo), 8'h00);
      set_reg(siow_pkg::IDX_FUNC_EN, 8'h00);
      set_reg(siow_pkg::IDX_COUNT, 8'h01);
      wait_tmo(40, n);
      chk("disabled", 8'(tmo), 8'h00);
      set_reg(siow_pkg::IDX_FUNC_EN, 8'h01);
      $display("t_refresh done");
   endtask : t_refresh
   task automatic t_activity();
      logic [7:0] en [3] = '{8'h00, 8'h40, 8'h80};
      int         e;
      int         n;
      foreach (en[k]) begin
         set_reg(siow_pkg::IDX_CTRL, en[k]);
         set_reg(siow_pkg::IDX_COUNT, 8'h02);
         repeat (5) @(posedge core_clk_i);
         #1 kbd = (k != 2);
         mouse = (k != 1);
         @(posedge core_clk_i) #1;
         kbd = 1'b0;
         mouse = 1'b0;
         e = (k == 0) ? 2 * UMS - 6 : 2 * UMS;
         wait_tmo(40, n);
         chk("activity", 8'(n >= e && n <= e + 3), 8'h01);
      end
      $display("t_activity done");
   endtask : t_activity
   // a low clock enable holds the countdown still
   task automatic t_freeze();
      int n;
      set_reg(siow_pkg::IDX_COUNT, 8'h02);
      clk_en = 1'b0;
      repeat (20) @(posedge core_clk_i);
      #1 clk_en = 1'b1;
      wait_tmo(40, n);
      chk("frozen count", 8'(n >= 2 * UMS && n <= 2 * UMS + 3), 8'h01);
      $display("t_freeze done");
   endtask : t_freeze
   task automatic t_force();
      logic [7:0] d;
      set_reg(siow_pkg::IDX_CTRL, 8'h20);
      chk("forced pulse", 8'(tmo), 8'h01);
      get_reg(siow_pkg::IDX_CTRL, d);
      chk("force bits", 8'(d[5:4]), 8'h01);
      $display("t_force done");
   endtask : t_force
   // watchdog against a hang
   initial begin
      #100us;
      mismatches++;
      summarize();
   end
   // main sequence
   initial begin
      repeat (10) @(posedge core_clk_i);
      #1 rst_n_i = 1'b1;
      t_reset();
      t_lock();
      t_expire();
      t_refresh();
      t_activity();
      t_freeze();
      t_force();
      summarize();
   end
endmodule : siow_watchdog_tb
